// ===== verilog/tch_pkg.sv
// Package: constants and types of the tape controller host port
// Summary of operation
// - Write-only control enables register at 292h
// - Mode register at 293h holds interrupt enable
// - Mode bit high selects dual-step DMA
// - Mode bit high selects diagnostic mode
// - Step select low stops clock, host steps
// - Mode bit selects drive capacity timing
// - Status at 293h: error, interrupt active low
// - Status shows filemark, cartridge swap, writing
// - Status shows internal DMA requests zero, one
// - Read done latched low, raises interrupt
// - Read error interrupts; write 291h clears
// - Read of 291h pulses read start
// - Read of 292h steps clock if selected
// - Single-step: channel 3 carries request zero when writing, request one otherwise
// - Dual-step: writes channel 3, reads channel 1
// - Write completion raises interrupt indication
// - Hard mark byte FF encodes unique code
// - Dual read: unique code sets filemark flag
// - Dual: data channel 3, block id channel 0
// - Diagnostic read data is fixed AA
// - Tape interrupt forwarded to host request line
package tch_pkg;
   localparam int         ADDR_W        = 10;
   localparam logic [9:0] ADR_DRIVE_ST  = 10'h290;
   localparam logic [9:0] ADR_STROBES   = 10'h291;
   localparam logic [9:0] ADR_CONTROL   = 10'h292;
   localparam logic [9:0] ADR_MODE_ST   = 10'h293;
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [7:0] MODE_RST      = 8'h10;
   localparam logic [7:0] MARK_BYTE     = 8'hff;
   localparam logic [9:0] MARK_CODE     = 10'h0a5;
   localparam logic [7:0] DIAG_BYTE     = 8'haa;
   localparam int         SYNC_STAGES   = 3;

   typedef struct packed {
      logic dma_ch3_route_en;
      logic write_counter_en;
      logic hard_mark_en;
      logic write_en;
      logic dma_ch1_route_en;
      logic read_gate_en;
      logic read_sequencer_en;
      logic drive_if_en;
   } tch_ctrl_t;

   typedef struct packed {
      logic       irq_en;
      logic       diag_mode;
      logic       dual_mode;
      logic       rsvd_mode;
      logic       step_clock_sel_n;
      logic       capacity_sel;
      logic [1:0] rsvd;
   } tch_mode_t;

   typedef struct packed {
      logic writing_data_flag;
      logic error_flag_n;
      logic read_done_n;
      logic filemark;
      logic cartridge_swapped;
      logic irq_n;
      logic internal_req_one;
      logic internal_req_zero;
   } tch_status_t;
endpackage

// ===== verilog/tch_host_port.sv
// Host port of the tape controller: registers, strobes, DMA and interrupt routing
`timescale 1ns/1ps
`default_nettype none
module tch_host_port
   import tch_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   input  wire logic              i_ior_n,
   input  wire logic              i_iow_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_host_data,
   output logic      [7:0]        o_host_data,
   output logic                   o_host_data_oe,
   input  wire logic [3:0]        i_drive_pins_n,
   input  wire logic              i_internal_req_zero,
   input  wire logic              i_internal_req_one,
   input  wire logic              i_id_req,
   input  wire logic              i_writing_data,
   input  wire logic              i_cartridge_swapped,
   input  wire logic              i_read_done,
   input  wire logic              i_read_error,
   input  wire logic              i_write_done,
   input  wire logic [9:0]        i_rd_code,
   input  wire logic              i_rd_code_valid,
   input  wire logic [7:0]        i_seq_rd_byte,
   input  wire logic [7:0]        i_wr_byte,
   input  wire logic              i_wr_byte_valid,
   output tch_ctrl_t              o_ctrl,
   output tch_mode_t              o_mode,
   output logic                   o_read_start_strobe_n,
   output logic                   o_controller_clk_en,
   output logic                   o_host_dma_req_ch3,
   output logic                   o_host_dma_req_ch1,
   output logic                   o_host_dma_req_ch0,
   output logic                   o_host_irq,
   output logic      [7:0]        o_rd_byte,
   output logic      [9:0]        o_wr_code,
   output logic                   o_wr_is_mark
);
   // Pin synchronisers; stage 0 is only read by stage 1
   logic [SYNC_STAGES-1:0] ior_s_ff, iow_s_ff, nxt_ior_s, nxt_iow_s;
   logic [3:0]             drv_s0_ff, drv_s1_ff, drv_s2_ff, drv_ff, nxt_drv;
   logic                   ior_ff, iow_ff, nxt_ior, nxt_iow;

   function automatic logic agreed(input logic [SYNC_STAGES-1:0] s, input logic old);
      agreed = (s[1] == s[2]) ? s[2] : old;
   endfunction

   always_comb begin
      nxt_ior_s = {ior_s_ff[1:0], ~i_ior_n};
      nxt_iow_s = {iow_s_ff[1:0], ~i_iow_n};
      nxt_ior   = agreed(ior_s_ff, ior_ff);
      nxt_iow   = agreed(iow_s_ff, iow_ff);
      nxt_drv   = drv_ff;
      for (int b = 0; b < 4; b++) begin
         if (drv_s1_ff[b] == drv_s2_ff[b]) begin
            nxt_drv[b] = drv_s2_ff[b];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ior_s_ff  <= '0;
         iow_s_ff  <= '0;
         ior_ff    <= 1'b0;
         iow_ff    <= 1'b0;
         drv_s0_ff <= 4'hf;
         drv_s1_ff <= 4'hf;
         drv_s2_ff <= 4'hf;
         drv_ff    <= 4'hf;
      end else begin
         ior_s_ff  <= nxt_ior_s;
         iow_s_ff  <= nxt_iow_s;
         ior_ff    <= nxt_ior;
         iow_ff    <= nxt_iow;
         drv_s0_ff <= i_drive_pins_n;
         drv_s1_ff <= drv_s0_ff;
         drv_s2_ff <= drv_s1_ff;
         drv_ff    <= nxt_drv;
      end
   end

   // Access starts; address held stable by the host for the whole strobe
   logic rd_start, wr_start;
   assign rd_start = nxt_ior & ~ior_ff;
   assign wr_start = nxt_iow & ~iow_ff;

   tch_ctrl_t   ctrl_ff, nxt_ctrl;
   tch_mode_t   mode_ff, nxt_mode;
   tch_status_t status;
   logic        irq_flag_ff, nxt_irq_flag, err_ff, nxt_err, done_ff, nxt_done;
   logic        mark_ff, nxt_mark, rs_ff, nxt_rs, clk_en_ff, nxt_clk_en;
   logic        ch3_ff, ch1_ff, ch0_ff, nxt_ch3, nxt_ch1, nxt_ch0;
   logic [7:0]  hdata_ff, nxt_hdata, rdb_ff, nxt_rdb;
   logic        hoe_ff, nxt_hoe, hirq_ff, nxt_hirq, wmark_ff, nxt_wmark;
   logic [9:0]  wcode_ff, nxt_wcode;

   always_comb begin
      status = '{writing_data_flag: i_writing_data,
                 error_flag_n:      ~err_ff,
                 read_done_n:       ~done_ff,
                 filemark:          mark_ff,
                 cartridge_swapped: i_cartridge_swapped,
                 irq_n:             ~irq_flag_ff,
                 internal_req_one:  i_internal_req_one,
                 internal_req_zero: i_internal_req_zero};
      nxt_ctrl = ctrl_ff;
      nxt_mode = mode_ff;
      if (wr_start && i_addr == ADR_CONTROL) begin
         nxt_ctrl = tch_ctrl_t'(i_host_data);
      end
      if (wr_start && i_addr == ADR_MODE_ST) begin
         nxt_mode = tch_mode_t'(i_host_data);
      end
      // Set wins over the host clear
      nxt_err      = i_read_error | (err_ff & ~(wr_start && i_addr == ADR_STROBES));
      nxt_irq_flag = i_read_done | i_read_error | i_write_done |
                     (irq_flag_ff & ~(wr_start && i_addr == ADR_STROBES));
      nxt_rs       = ~(rd_start && i_addr == ADR_STROBES);
      nxt_done     = i_read_done | (done_ff & nxt_rs);
      nxt_mark     = (mode_ff.dual_mode && ctrl_ff.read_gate_en && i_rd_code_valid &&
                      i_rd_code == MARK_CODE) | (mark_ff & nxt_rs);
      // Normal clock runs unless stepping is selected; then one pulse per read of 292h
      nxt_clk_en   = mode_ff.step_clock_sel_n |
                     (rd_start && i_addr == ADR_CONTROL);
      if (mode_ff.dual_mode) begin
         nxt_ch3 = ctrl_ff.dma_ch3_route_en & i_internal_req_zero;
         nxt_ch1 = ctrl_ff.dma_ch1_route_en & i_internal_req_one;
         nxt_ch0 = ctrl_ff.read_gate_en & i_id_req;
      end else begin
         nxt_ch3 = ctrl_ff.dma_ch3_route_en &
                   (ctrl_ff.write_en ? i_internal_req_zero : i_internal_req_one);
         nxt_ch1 = ctrl_ff.dma_ch1_route_en & i_internal_req_one;
         nxt_ch0 = 1'b0;
      end
      nxt_hirq  = mode_ff.irq_en & irq_flag_ff;
      nxt_hoe   = nxt_ior && (i_addr == ADR_DRIVE_ST || i_addr == ADR_MODE_ST);
      nxt_hdata = hdata_ff;
      if (rd_start) begin
         nxt_hdata = (i_addr == ADR_MODE_ST) ? status : {drv_ff, 4'h0};
      end
      nxt_rdb   = mode_ff.diag_mode ? DIAG_BYTE : i_seq_rd_byte;
      nxt_wmark = i_wr_byte_valid & ctrl_ff.hard_mark_en & (i_wr_byte == MARK_BYTE);
      nxt_wcode = nxt_wmark ? MARK_CODE : {2'h0, i_wr_byte};
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_ff     <= tch_ctrl_t'(CTRL_RST);
         mode_ff     <= tch_mode_t'(MODE_RST);
         irq_flag_ff <= 1'b0;
         err_ff      <= 1'b0;
         done_ff     <= 1'b0;
         mark_ff     <= 1'b0;
         rs_ff       <= 1'b1;
         clk_en_ff   <= 1'b1;
         ch3_ff      <= 1'b0;
         ch1_ff      <= 1'b0;
         ch0_ff      <= 1'b0;
         hirq_ff     <= 1'b0;
         hoe_ff      <= 1'b0;
         hdata_ff    <= 8'h00;
         rdb_ff      <= 8'h00;
         wmark_ff    <= 1'b0;
         wcode_ff    <= 10'h000;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         mode_ff     <= nxt_mode;
         irq_flag_ff <= nxt_irq_flag;
         err_ff      <= nxt_err;
         done_ff     <= nxt_done;
         mark_ff     <= nxt_mark;
         rs_ff       <= nxt_rs;
         clk_en_ff   <= nxt_clk_en;
         ch3_ff      <= nxt_ch3;
         ch1_ff      <= nxt_ch1;
         ch0_ff      <= nxt_ch0;
         hirq_ff     <= nxt_hirq;
         hoe_ff      <= nxt_hoe;
         hdata_ff    <= nxt_hdata;
         rdb_ff      <= nxt_rdb;
         wmark_ff    <= nxt_wmark;
         wcode_ff    <= nxt_wcode;
      end
   end

   assign o_ctrl                = ctrl_ff;
   assign o_mode                = mode_ff;
   assign o_read_start_strobe_n = rs_ff;
   assign o_controller_clk_en   = clk_en_ff;
   assign o_host_dma_req_ch3    = ch3_ff;
   assign o_host_dma_req_ch1    = ch1_ff;
   assign o_host_dma_req_ch0    = ch0_ff;
   assign o_host_irq            = hirq_ff;
   assign o_host_data           = hdata_ff;
   assign o_host_data_oe        = hoe_ff;
   assign o_rd_byte             = rdb_ff;
   assign o_wr_code             = wcode_ff;
   assign o_wr_is_mark          = wmark_ff;

   // Checks
   sequence s_err_clear;
      wr_start && i_addr == ADR_STROBES && !i_read_error;
   endsequence
   sequence s_step_read;
      rd_start && i_addr == ADR_CONTROL && !mode_ff.step_clock_sel_n;
   endsequence

   AST_CTRL_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      wr_start && i_addr == ADR_CONTROL |=> o_ctrl == $past(i_host_data))
      else $error("control write not stored");
   AST_IRQ_GATE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !o_mode.irq_en && !$past(o_mode.irq_en) |-> !o_host_irq)
      else $error("interrupt passed while disabled");
   // Clock enable leaves reset high although the reset mode selects stepping
   AST_STEP_STOP: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !$past(i_reset) && !o_mode.step_clock_sel_n && !(rd_start && i_addr == ADR_CONTROL)
      |=> !o_controller_clk_en)
      else $error("clock ran while stepping selected");
   AST_STEP_PULSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_step_read |=> o_controller_clk_en ##1 !o_controller_clk_en)
      else $error("step pulse not one cycle");
   AST_ERR_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_err_clear |=> status.error_flag_n)
      else $error("error not cleared");
   AST_ERR_SET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      i_read_error |=> !status.error_flag_n && !status.irq_n)
      else $error("error not flagged");
   AST_DONE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      i_read_done |=> (!status.read_done_n and (o_mode.irq_en |=> o_host_irq)))
      else $error("read done not latched");
   AST_START: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      rd_start && i_addr == ADR_STROBES |=> !o_read_start_strobe_n ##1 o_read_start_strobe_n)
      else $error("read start pulse wrong");
   AST_MARK_ENC: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      i_wr_byte_valid && ctrl_ff.hard_mark_en && i_wr_byte == MARK_BYTE
      |=> o_wr_is_mark && o_wr_code == MARK_CODE)
      else $error("hard mark not encoded");
   AST_DIAG: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      mode_ff.diag_mode |=> o_rd_byte == DIAG_BYTE)
      else $error("diagnostic byte wrong");
   AST_SINGLE_ROUTE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !mode_ff.dual_mode && !ctrl_ff.dma_ch3_route_en |=> !o_host_dma_req_ch3)
      else $error("channel 3 request without enable");
endmodule // tch_host_port
`default_nettype wire

// ===== verif/tch_host_model.sv
// Host I/O bus model driving paced read and write strobes
`timescale 1ns/1ps
`default_nettype none
module tch_host_model
   import tch_pkg::*;
(
   input  wire logic              i_sys_clk,
   output logic                   o_ior_n,
   output logic                   o_iow_n,
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [7:0]        o_data
);
   initial begin
      o_ior_n = 1'b1;
      o_iow_n = 1'b1;
      o_addr  = '0;
      o_data  = '0;
   end
   // Strobe low six cycles: the sync chain needs three
   task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_data <= d;
      if (wr) begin
         o_iow_n <= 1'b0;
      end else begin
         o_ior_n <= 1'b0;
      end
      repeat (6) @(posedge i_sys_clk);
      o_iow_n <= 1'b1;
      o_ior_n <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      // Released bus keeps the old values four cycles, then shows inverted ones
      o_addr <= ~a;
      o_data <= ~d;
   endtask
endmodule // tch_host_model
`default_nettype wire

// ===== verif/tape_controller_host_port_tb_top.sv
// Self-checking bench of the tape controller host port
`timescale 1ns/1ps
`default_nettype none
module tape_controller_host_port_tb_top
   import tch_pkg::*;
;
   logic        clk, rst, ior_n, iow_n, oe, rs_n, clk_en, ch3, ch1, ch0, irq, is_mark, oe_q;
   logic [9:0]  addr, rd_code, wr_code;
   logic [7:0]  hdata, odata, seq_b, wb, rd_b, r;
   logic [4:0]  ev, lv;
   logic [3:0]  pins_n;
   logic [15:0] nt;
   logic [15:0] notes[$];
   tch_ctrl_t   ctrl;
   tch_mode_t   mode;
   int          fails, total_checks, steps, starts;
   integer      seed;
   localparam logic [7:0] MODE_SET [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   tch_host_model host (.i_sys_clk(clk), .o_ior_n(ior_n), .o_iow_n(iow_n), .o_addr(addr),
      .o_data(hdata));
   tch_host_port dut (.i_sys_clk(clk), .i_reset(rst), .i_ior_n(ior_n), .i_iow_n(iow_n),
      .i_addr(addr), .i_host_data(hdata), .o_host_data(odata), .o_host_data_oe(oe),
      .i_drive_pins_n(pins_n), .i_internal_req_zero(lv[0]), .i_internal_req_one(lv[1]),
      .i_id_req(lv[2]), .i_writing_data(lv[3]), .i_cartridge_swapped(lv[4]),
      .i_read_done(ev[0]), .i_read_error(ev[1]), .i_write_done(ev[2]),
      .i_rd_code(rd_code), .i_rd_code_valid(ev[3]), .i_seq_rd_byte(seq_b),
      .i_wr_byte(wb), .i_wr_byte_valid(ev[4]), .o_ctrl(ctrl), .o_mode(mode),
      .o_read_start_strobe_n(rs_n), .o_controller_clk_en(clk_en),
      .o_host_dma_req_ch3(ch3), .o_host_dma_req_ch1(ch1), .o_host_dma_req_ch0(ch0),
      .o_host_irq(irq), .o_rd_byte(rd_b), .o_wr_code(wr_code), .o_wr_is_mark(is_mark));

   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      host.access(1'b1, a, d);
   endtask
   // Expected read data is noted first, the monitor compares it
   task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
      notes.push_back({m, e});
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clk) ev <= v;
      @(posedge clk) ev <= 5'h00;
   endtask
   task automatic route(input logic [7:0] m, c, input logic [4:0] l, input logic [2:0] e);
      wr(ADR_MODE_ST, m);
      wr(ADR_CONTROL, c);
      @(posedge clk) lv <= l;
      settle(2);
      chk("dma routes", {7'h00, e}, {7'h00, ch3, ch1, ch0});
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      oe_q <= oe;
      if (clk_en === 1'b1) steps++;
      if (rs_n === 1'b0) starts++;
      if (oe === 1'b1 && oe_q !== 1'b1) begin
         if (notes.size() == 0) begin
            fails++;
            $display("unexpected read data: expected none seen %h", odata);
         end else begin
            nt = notes.pop_front();
            chk("read data", {2'b00, nt[7:0]}, {2'b00, odata & nt[15:8]});
         end
      end
   end

   initial begin
      #60000;
      fails++;
      $display("unexpected run length: expected finish seen hang");
      complete_run();
   end

   initial begin
      seed = 32'hbcb455e6;
      rst = 1'b1;
      ev = '0;
      lv = '0;
      pins_n = 4'hf;
      rd_code = '0;
      seq_b = '0;
      wb = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      pins_n <= 4'($random(seed));
      lv <= 5'b10001;
      settle(1);
      chk("ctrl", {2'b00, CTRL_RST}, {2'b00, ctrl});
      chk("mode", {2'b00, MODE_RST}, {2'b00, mode});
      rd(ADR_MODE_ST, 8'hff, 8'h6d);
      rd(ADR_DRIVE_ST, 8'hf0, {pins_n, 4'h0});
      host.access(1'b0, 10'h2a0, 8'h00);
      $display("test status done");
      r = 8'($random(seed));
      wr(ADR_CONTROL, r);
      wr(ADR_DRIVE_ST, ~r);
      settle(1);
      chk("ctrl", {2'b00, r}, {2'b00, ctrl});
      foreach (MODE_SET[i]) begin
         wr(ADR_MODE_ST, MODE_SET[i]);
         settle(1);
         chk("mode", {2'b00, MODE_SET[i]}, {2'b00, mode});
      end
      $display("test registers done");
      wr(ADR_MODE_ST, 8'h08);
      settle(1);
      steps = 0;
      settle(8);
      chk("clock run", 10'd8, 10'(steps));
      wr(ADR_MODE_ST, 8'h00);
      settle(1);
      steps = 0;
      starts = 0;
      host.access(1'b0, ADR_CONTROL, 8'h00);
      settle(4);
      chk("step pulses", 10'd1, 10'(steps));
      host.access(1'b0, ADR_STROBES, 8'h00);
      settle(4);
      chk("start pulses", 10'd1, 10'(starts));
      chk("step pulses", 10'd1, 10'(steps));
      $display("test strobes done");
      wr(ADR_MODE_ST, 8'h88);
      @(posedge clk) lv <= 5'b01010;
      pulse(5'b00001);
      settle(3);
      chk("irq", 10'd1, {9'h000, irq});
      rd(ADR_MODE_ST, 8'hff, 8'hc2);
      wr(ADR_STROBES, 8'h00);
      settle(2);
      chk("irq", 10'd0, {9'h000, irq});
      pulse(5'b00010);
      settle(3);
      chk("irq", 10'd1, {9'h000, irq});
      rd(ADR_MODE_ST, 8'h44, 8'h00);
      wr(ADR_STROBES, 8'h00);
      settle(2);
      chk("irq", 10'd0, {9'h000, irq});
      rd(ADR_MODE_ST, 8'h44, 8'h44);
      pulse(5'b00100);
      settle(3);
      chk("irq", 10'd1, {9'h000, irq});
      wr(ADR_MODE_ST, 8'h08);
      wr(ADR_STROBES, 8'h00);
      pulse(5'b00100);
      settle(3);
      chk("irq", 10'd0, {9'h000, irq});
      $display("test interrupts done");
      route(8'h08, 8'h90, 5'b00001, 3'b100);
      route(8'h08, 8'h80, 5'b00010, 3'b100);
      route(8'h08, 8'h80, 5'b00001, 3'b000);
      route(8'h28, 8'h8c, 5'b00111, 3'b111);
      route(8'h28, 8'h08, 5'b00111, 3'b010);
      // Mark detection needs the read gate open
      wr(ADR_CONTROL, 8'h06);
      @(posedge clk) rd_code <= MARK_CODE;
      pulse(5'b01000);
      settle(2);
      rd(ADR_MODE_ST, 8'h10, 8'h10);
      $display("test routing done");
      @(posedge clk) seq_b <= 8'($random(seed));
      wr(ADR_MODE_ST, 8'h48);
      settle(2);
      chk("read byte", {2'b00, DIAG_BYTE}, {2'b00, rd_b});
      wr(ADR_MODE_ST, 8'h08);
      settle(2);
      chk("read byte", {2'b00, seq_b}, {2'b00, rd_b});
      wr(ADR_CONTROL, 8'h20);
      @(posedge clk) wb <= MARK_BYTE;
      pulse(5'b10000);
      #1;
      chk("mark code", MARK_CODE, wr_code);
      chk("mark flag", 10'd1, {9'h000, is_mark});
      $display("test data path done");
      chk("pending reads", 10'd0, 10'(notes.size()));
      complete_run();
   end
endmodule // tape_controller_host_port_tb_top
`default_nettype wire
